// [logic/alarm_ctrl_pkg.sv]
// Constants and types for the alarm front end control and sleep register slice.
// Assumes a byte wide register port behind the serial interface decoder.
package alarm_ctrl_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_ENABLE_SECOND = 8'h07;
  localparam logic [7:0] ADDR_CONTROL_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_SLEEP_HIGH    = 8'h09;
  localparam logic [7:0] ADDR_SLEEP_LOW     = 8'h0A;
  localparam logic [7:0] ADDR_PIN_MUX       = 8'h0B;

  // Reset values.
  localparam logic [7:0] RST_ENABLE_SECOND = 8'h00;
  localparam logic [7:0] RST_CONTROL_FLAGS = 8'h00;
  localparam logic [7:0] RST_SLEEP_BYTE    = 8'h00;
  localparam logic [7:0] RST_PIN_MUX       = 8'h00;

  // Field positions of enable_second.
  localparam int EN2_LED_SELECT = 7;
  localparam int EN2_PRECHARGE  = 6;
  localparam int EN2_LINK_DIR   = 3;
  localparam int EN2_LED_GATE   = 2;
  localparam int EN2_HORN_EN    = 1;
  localparam int EN2_SLEEP_EN   = 0;
  localparam logic [7:0] EN2_WRITABLE = 8'hCF;

  // Field positions of control_flags.
  localparam int CTL_REG_OFF     = 5;
  localparam int CTL_MON_OFF     = 4;
  localparam int CTL_FAULT_MASK  = 3;
  localparam int CTL_OT_ENABLE   = 2;
  localparam int CTL_REINIT      = 1;
  localparam int CTL_BOOST_ASSIST = 0;
  localparam logic [7:0] CTL_WRITABLE = 8'h3D;

  // Field positions of pin_and_mux_config.
  localparam int PMX_BYPASS   = 7;
  localparam int PMX_SEL_LSB  = 4;
  localparam int PMX_SEL_MSB  = 5;
  localparam int PMX_PIN_LSB  = 0;
  localparam int PMX_PIN_MSB  = 2;
  localparam logic [7:0] PMX_WRITABLE = 8'hB7;

  // Analog mux selections.
  localparam logic [1:0] AMUX_OFF   = 2'h0;
  localparam logic [1:0] AMUX_CO    = 2'h1;
  localparam logic [1:0] AMUX_PHOTO = 2'h2;
  localparam logic [1:0] AMUX_DIODE = 2'h3;

  // Multi-purpose pin modes.
  localparam logic [2:0] PIN_HIZ     = 3'h0;
  localparam logic [2:0] PIN_ERROR   = 3'h2;
  localparam logic [2:0] PIN_LED_A   = 3'h4;
  localparam logic [2:0] PIN_LED_B   = 3'h5;
  localparam logic [2:0] PIN_BATTERY = 3'h7;

  // Sleep timer granularity.
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_MS  = 1;
  localparam int NS_PER_MS     = 1000000;
  localparam int TICK_CYCLES   = (TICK_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam logic [15:0] SLEEP_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    SLEEP_IDLE  = 2'b00,
    SLEEP_ARMED = 2'b01,
    SLEEP_RUN   = 2'b10
  } sleep_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [logic/alarm_afe_control_sleep_regs.sv]
// Control, sleep timer and pin/mux configuration registers of the alarm front end.
// Assumes the serial interface decoder presents one-cycle read and write strobes
// synchronous to clk, and that the analog blocks consume the enables below.
//
// Summary of operation
// R1 - Precharge request keeps boost on until power good, then boost follows enable.
// R2 - Host clears the precharge request after seeing power good.
// R3 - Direction bit routes link from alarm pin to host pin, or reverse.
// R4 - LED enable pin acts only when the LED pin gate bit is set.
// R5 - Horn block enabled by horn drive pin only while horn enable set.
// R6 - Writing sleep enable starts timer; expiry raises done and clears enable.
// R7 - Writing sleep enable zero stops the timer and exits sleep at once.
// R8 - Regulator off bit disables the host regulator; reset leaves it on.
// R9 - Monitor off bit disables the brown-out monitor and its low flag.
// R10 - Unmasked regulator error enters fault mode; mask bit blocks it.
// R11 - Over-temperature enable makes overheating enter fault mode and raise flag.
// R12 - Reinit restores defaults including boost assist, self-clears, spares only the precharge setting.
// R13 - Boost assist turns boost on when supply low or boost enable set.
// R14 - Sleep duration is high byte then low byte, N milliseconds.
// R15 - Duration rewrites during a running sleep apply at the next start.
// R16 - Zero duration disables timer; a later duration change starts it.
// R17 - Mux buffer on for nonzero select unless bypassed by a switch.
// R18 - Mux select picks off, CO amp, photo amp or photodiode.
// R19 - Pin mode zero is high impedance; mode two shows unmasked errors.
// R20 - Pin modes four and five OR the pin into LED A or LED B.
// R21 - Pin mode seven ORs the pin into the battery test load.
// R22 - Reserved bits read zero; host avoids reserved pin codes.
`timescale 1ns/1ps
module alarm_afe_control_sleep_regs #(
  parameter int TICK_CYCLES_P = alarm_ctrl_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // Register port
  input  wire alarm_ctrl_pkg::reg_req_t reg_req,
  output logic [7:0]                   reg_rdata,
  // Boost control
  input  wire logic                    boost_enable_bit,
  input  wire logic                    boost_power_good,
  output logic                         boost_run,
  // Supervision
  input  wire logic                    supply_low_detect,
  input  wire logic                    regulator_error,
  input  wire logic                    overtemp_event,
  output logic                         supply_low_flag,
  output logic                         host_regulator_enable,
  output logic                         fault_mode,
  output logic                         overtemp_flag,
  // Interconnect pins
  input  wire logic                    alarm_link_in,
  output logic                         alarm_link_out,
  output logic                         alarm_link_oe_n,
  input  wire logic                    host_link_in,
  output logic                         host_link_out,
  output logic                         host_link_oe_n,
  // LED and horn
  input  wire logic                    led_enable_pin,
  input  wire logic                    horn_drive_pin,
  input  wire logic                    led_a_enable_input,
  input  wire logic                    led_b_enable_input,
  input  wire logic                    battery_load_enable,
  output logic                         led_block_enable,
  output logic                         led_select,
  output logic                         led_a_enable,
  output logic                         led_b_enable,
  output logic                         battery_load_on,
  output logic                         horn_block_enable,
  // Sleep
  output logic                         sleep_mode,
  output logic                         sleep_expired_flag,
  // Analog mux
  output logic [1:0]                   analog_mux_select,
  output logic                         amux_buffer_enable,
  output logic                         amux_bypass_switch,
  // Multi-purpose pin
  input  wire logic                    status_error_any,
  input  wire logic                    gpio_in,
  output logic                         gpio_out,
  output logic                         gpio_oe_n
);
  import alarm_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode.

  logic [7:0]   enable_second;
  logic [7:0]   control_flags;
  logic [7:0]   sleep_time_high;
  logic [7:0]   sleep_time_low;
  logic [7:0]   pin_and_mux_config;
  logic         precharging;
  logic [15:0]  sleep_left;
  logic [31:0]  tick_count;
  sleep_state_t sleep_state;

  logic wr_en2;
  logic wr_ctl;
  logic wr_hi;
  logic wr_lo;
  logic wr_pmx;
  logic reinit;
  logic sleep_write_one;
  logic sleep_write_zero;
  logic duration_change;
  logic expire;
  logic [15:0] sleep_duration;

  assign wr_en2 = reg_req.wr && (reg_req.addr == ADDR_ENABLE_SECOND);
  assign wr_ctl = reg_req.wr && (reg_req.addr == ADDR_CONTROL_FLAGS);
  assign wr_hi  = reg_req.wr && (reg_req.addr == ADDR_SLEEP_HIGH);
  assign wr_lo  = reg_req.wr && (reg_req.addr == ADDR_SLEEP_LOW);
  assign wr_pmx = reg_req.wr && (reg_req.addr == ADDR_PIN_MUX);
  assign reinit = wr_ctl && reg_req.wdata[CTL_REINIT];  // see R12
  assign sleep_write_one  = wr_en2 && reg_req.wdata[EN2_SLEEP_EN];
  assign sleep_write_zero = wr_en2 && !reg_req.wdata[EN2_SLEEP_EN];
  assign sleep_duration = {sleep_time_high, sleep_time_low};  // see R14
  assign duration_change = (wr_hi && (reg_req.wdata != sleep_time_high)) ||
                           (wr_lo && (reg_req.wdata != sleep_time_low));
  assign expire = (sleep_state == SLEEP_RUN) && (sleep_left == 16'h0001) &&
                  (tick_count == 32'(TICK_CYCLES_P - 1));

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  // The precharge bit survives reinit, so reinit carries it over while the other bits reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_second <= RST_ENABLE_SECOND;
    end else if (reinit) begin
      enable_second <= RST_ENABLE_SECOND | (enable_second & (8'h01 << EN2_PRECHARGE)); // see R12
    end else if (wr_en2) begin
      enable_second <= reg_req.wdata & EN2_WRITABLE;  // see R22
    end else if (expire) begin
      enable_second[EN2_SLEEP_EN] <= 1'b0;  // see R6
    end
  end

  // The reinit bit never stores, so it always reads back as zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_flags <= RST_CONTROL_FLAGS;
    end else if (reinit) begin
      control_flags <= RST_CONTROL_FLAGS;  // see R12
    end else if (wr_ctl) begin
      control_flags <= reg_req.wdata & CTL_WRITABLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_time_high <= RST_SLEEP_BYTE;
      sleep_time_low  <= RST_SLEEP_BYTE;
    end else if (reinit) begin
      sleep_time_high <= RST_SLEEP_BYTE;
      sleep_time_low  <= RST_SLEEP_BYTE;
    end else begin
      if (wr_hi) begin
        sleep_time_high <= reg_req.wdata;  // see R14
      end
      if (wr_lo) begin
        sleep_time_low <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_and_mux_config <= RST_PIN_MUX;
    end else if (reinit) begin
      pin_and_mux_config <= RST_PIN_MUX;
    end else if (wr_pmx) begin
      pin_and_mux_config <= reg_req.wdata & PMX_WRITABLE;  // see R22
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_ENABLE_SECOND: reg_rdata <= enable_second;
        ADDR_CONTROL_FLAGS: reg_rdata <= control_flags;
        ADDR_SLEEP_HIGH:    reg_rdata <= sleep_time_high;
        ADDR_SLEEP_LOW:     reg_rdata <= sleep_time_low;
        ADDR_PIN_MUX:       reg_rdata <= pin_and_mux_config;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Boost precharge.

  // Precharge ends at power good; a fresh 0-to-1 write of the request rearms it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      precharging <= 1'b0;
    end else if (wr_en2 && reg_req.wdata[EN2_PRECHARGE] && !enable_second[EN2_PRECHARGE]) begin
      precharging <= 1'b1;  // see R1
    end else if (boost_power_good || !enable_second[EN2_PRECHARGE]) begin
      precharging <= 1'b0;  // see R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep timer.

  // The count is a private copy, so duration rewrites never disturb a running sleep.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_state        <= SLEEP_IDLE;
      sleep_left         <= SLEEP_ZERO;
      tick_count         <= 32'h0;
      sleep_expired_flag <= 1'b0;
    end else begin
      sleep_expired_flag <= expire;  // see R6
      if (reinit || sleep_write_zero) begin
        sleep_state <= SLEEP_IDLE;  // see R7
      end else if (sleep_write_one && sleep_state == SLEEP_IDLE) begin
        tick_count <= 32'h0;
        sleep_left <= sleep_duration;  // see R6
        sleep_state <= (sleep_duration == SLEEP_ZERO) ? SLEEP_ARMED : SLEEP_RUN; // see R16
      end else begin
        case (sleep_state)
          SLEEP_ARMED: begin
            if (duration_change) begin
              tick_count  <= 32'h0;
              sleep_left  <= wr_hi ? {reg_req.wdata, sleep_time_low}
                                   : {sleep_time_high, reg_req.wdata};
              sleep_state <= SLEEP_RUN;  // see R16
            end
          end
          SLEEP_RUN: begin
            if (tick_count == 32'(TICK_CYCLES_P - 1)) begin
              tick_count <= 32'h0;
              sleep_left <= sleep_left - 16'h0001;  // see R14
              if (expire) begin
                sleep_state <= SLEEP_IDLE;
              end
            end else begin
              tick_count <= tick_count + 32'h1;  // see R15
            end
          end
          default: sleep_state <= SLEEP_IDLE;
        endcase
      end
    end
  end

  // A new duration of zero while armed keeps waiting.
  assign sleep_mode = enable_second[EN2_SLEEP_EN];

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      supply_low_flag       <= 1'b0;
      host_regulator_enable <= 1'b1;
      fault_mode            <= 1'b0;
      overtemp_flag         <= 1'b0;
    end else begin
      supply_low_flag       <= supply_low_detect && !control_flags[CTL_MON_OFF];  // see R9
      host_regulator_enable <= !control_flags[CTL_REG_OFF];  // see R8
      fault_mode <= (regulator_error && !control_flags[CTL_FAULT_MASK]) ||  // see R10
                    (overtemp_event && control_flags[CTL_OT_ENABLE]);       // see R11
      overtemp_flag <= overtemp_event && control_flags[CTL_OT_ENABLE];      // see R11
    end
  end

  assign boost_run = boost_enable_bit || precharging ||  // see R1
                     (control_flags[CTL_BOOST_ASSIST] && supply_low_flag);  // see R13

  // Each link pin is driven only in its own direction to avoid contention.
  assign host_link_out   = alarm_link_in;  // see R3
  assign alarm_link_out  = host_link_in;   // see R3
  assign host_link_oe_n  = enable_second[EN2_LINK_DIR];
  assign alarm_link_oe_n = !enable_second[EN2_LINK_DIR];

  assign led_block_enable  = enable_second[EN2_LED_GATE] && led_enable_pin;  // see R4
  assign led_select        = enable_second[EN2_LED_SELECT];
  assign horn_block_enable = enable_second[EN2_HORN_EN] && horn_drive_pin; // see R5

  logic [2:0] pin_mode;
  assign pin_mode = pin_and_mux_config[PMX_PIN_MSB:PMX_PIN_LSB];
  assign analog_mux_select  = pin_and_mux_config[PMX_SEL_MSB:PMX_SEL_LSB];  // see R18
  assign amux_buffer_enable = !pin_and_mux_config[PMX_BYPASS] &&
                              (analog_mux_select != AMUX_OFF);  // see R17
  assign amux_bypass_switch = pin_and_mux_config[PMX_BYPASS] &&
                              (analog_mux_select != AMUX_OFF);  // see R17

  assign led_a_enable    = led_a_enable_input || ((pin_mode == PIN_LED_A) && gpio_in); // see R20
  assign led_b_enable    = led_b_enable_input || ((pin_mode == PIN_LED_B) && gpio_in); // see R20
  assign battery_load_on = battery_load_enable || ((pin_mode == PIN_BATTERY) && gpio_in); // see R21

  // Reserved pin codes leave the pin undriven as the safest choice.
  assign gpio_oe_n = (pin_mode != PIN_ERROR);  // see R19
  assign gpio_out  = (pin_mode == PIN_ERROR) && status_error_any;  // see R19

endmodule

// [bench/alarm_host_model.sv]
// Host microcontroller model that issues byte reads and writes on the register port.
// Assumes one-cycle strobes launched on the falling edge and read data one edge later.
`timescale 1ns/1ps
module alarm_host_model (
  // Register port
  input  wire logic                     clk,
  output alarm_ctrl_pkg::reg_req_t      reg_req,
  input  wire logic [7:0]               reg_rdata
);
  import alarm_ctrl_pkg::*;

  initial reg_req = '0;

  // The strobe is held across exactly one rising edge so each call is one transfer.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    reg_req.rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

// [bench/alarm_afe_control_sleep_regs_checker.sv]
// Concurrent checks on the top-level ports of the alarm control slice.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
module alarm_afe_control_sleep_regs_checker #(
  parameter int TICK_CYCLES_P = 4
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       boost_enable_bit,
  input wire logic       boost_run,
  input wire logic       alarm_link_in,
  input wire logic       alarm_link_out,
  input wire logic       alarm_link_oe_n,
  input wire logic       host_link_in,
  input wire logic       host_link_out,
  input wire logic       host_link_oe_n,
  input wire logic       led_enable_pin,
  input wire logic       led_block_enable,
  input wire logic       horn_drive_pin,
  input wire logic       horn_block_enable,
  input wire logic       sleep_mode,
  input wire logic       sleep_expired_flag,
  input wire logic [1:0] analog_mux_select,
  input wire logic       amux_buffer_enable,
  input wire logic       amux_bypass_switch,
  input wire logic       status_error_any,
  input wire logic       gpio_out,
  input wire logic       gpio_oe_n,
  input wire logic       overtemp_flag,
  input wire logic       fault_mode
);
  default clocking main_cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_BOOST_ENABLE: assert property (boost_enable_bit |-> boost_run)
    else $error("boost off while enable set");
  // Two drivers on one interconnect wire would fight, so exactly one side drives.
  AST_LINK_EXCL: assert property (host_link_oe_n != alarm_link_oe_n)
    else $error("link pins not in opposite drive states");
  AST_LINK_UP: assert property (!host_link_oe_n |-> host_link_out == alarm_link_in)
    else $error("host link does not follow alarm link");
  AST_LINK_DOWN: assert property (!alarm_link_oe_n |-> alarm_link_out == host_link_in)
    else $error("alarm link does not follow host link");
  AST_LED_GATE: assert property (led_block_enable |-> led_enable_pin)
    else $error("led block enabled without pin");
  AST_HORN: assert property (horn_block_enable |-> horn_drive_pin)
    else $error("horn enabled without drive pin");
  AST_GPIO: assert property (!gpio_oe_n |-> gpio_out == status_error_any)
    else $error("pin output differs from error status");
  AST_MUX: assert property (amux_buffer_enable |-> analog_mux_select != 2'h0 && !amux_bypass_switch)
    else $error("mux buffer on while off or bypassed");
  AST_EXPIRY: assert property (sleep_expired_flag |-> !sleep_mode && $past(sleep_mode) ##1 !sleep_expired_flag)
    else $error("expiry pulse without sleep end");
  AST_OT: assert property (overtemp_flag |-> fault_mode)
    else $error("overtemp flag without fault mode");

  COV_EXPIRY: cover property (sleep_expired_flag);
  COV_FAULT: cover property (fault_mode);
  COV_PIN_DRIVE: cover property (!gpio_oe_n && gpio_out);
endmodule

bind alarm_afe_control_sleep_regs alarm_afe_control_sleep_regs_checker #(
  .TICK_CYCLES_P(TICK_CYCLES_P)
) checker_i (
  .clk(clk), .rstn(rstn), .boost_enable_bit(boost_enable_bit), .boost_run(boost_run),
  .alarm_link_in(alarm_link_in), .alarm_link_out(alarm_link_out),
  .alarm_link_oe_n(alarm_link_oe_n), .host_link_in(host_link_in),
  .host_link_out(host_link_out), .host_link_oe_n(host_link_oe_n),
  .led_enable_pin(led_enable_pin), .led_block_enable(led_block_enable),
  .horn_drive_pin(horn_drive_pin), .horn_block_enable(horn_block_enable),
  .sleep_mode(sleep_mode), .sleep_expired_flag(sleep_expired_flag),
  .analog_mux_select(analog_mux_select), .amux_buffer_enable(amux_buffer_enable),
  .amux_bypass_switch(amux_bypass_switch), .status_error_any(status_error_any),
  .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .overtemp_flag(overtemp_flag),
  .fault_mode(fault_mode)
);

// [bench/tb_alarm_afe_control_sleep_regs.sv]
// Self-checking bench for the alarm control, sleep timer and pin/mux registers.
// Assumes the host model on the register port; the millisecond tick is cut to 4 cycles.
`timescale 1ns/1ps
module tb_alarm_afe_control_sleep_regs;
  import alarm_ctrl_pkg::*;
  localparam int TICK = 4;
  logic clk, rstn, boost_enable_bit, boost_power_good, boost_run, supply_low_detect;
  logic regulator_error, overtemp_event, supply_low_flag, host_regulator_enable;
  logic fault_mode, overtemp_flag, alarm_link_in, alarm_link_out, alarm_link_oe_n;
  logic host_link_in, host_link_out, host_link_oe_n, led_enable_pin, horn_drive_pin;
  logic led_a_enable_input, led_b_enable_input, battery_load_enable, led_block_enable;
  logic led_select, led_a_enable, led_b_enable, battery_load_on, horn_block_enable;
  logic sleep_mode, sleep_expired_flag, amux_buffer_enable, amux_bypass_switch;
  logic status_error_any, gpio_in, gpio_out, gpio_oe_n;
  logic [1:0] analog_mux_select;
  logic [7:0] reg_rdata, rd_val;
  reg_req_t   reg_req;
  int         num_errors, comparisons, cycles;
  logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h7};
  logic [3:0] pexp [5] = '{4'b1000, 4'b0000, 4'b1100, 4'b1010, 4'b1001};

  alarm_afe_control_sleep_regs #(.TICK_CYCLES_P(TICK)) DUT (.*);
  alarm_host_model host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Ceiling sits well above the longest sleep wait so only a hang reaches it.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      final_report;
    end
  end

  task automatic cv(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cb(input logic got, input logic exp);
    cv(8'(got), 8'(exp));
  endtask

  task automatic cr(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rd_val);
    comparisons++;
    if (rd_val !== exp) begin
      num_errors++;
      $display("[FAIL] %0t reg %h read %h expected %h", $time, a, rd_val, exp);
    end
  endtask

  // Counts falling edges until the expiry pulse; a cap of 40 means none was seen.
  task automatic swait(input int start, input int exp);
    int n;
    n = start;
    while (sleep_expired_flag !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    comparisons++;
    if (n != exp) begin
      num_errors++;
      $display("[FAIL] %0t expiry after %0d expected %0d", $time, n, exp);
    end
  endtask

  task automatic t_reset;
    cr(ADDR_ENABLE_SECOND, RST_ENABLE_SECOND);
    cr(ADDR_CONTROL_FLAGS, RST_CONTROL_FLAGS);
    cr(ADDR_SLEEP_HIGH, RST_SLEEP_BYTE);
    cr(ADDR_PIN_MUX, RST_PIN_MUX);
    cb(host_regulator_enable, 1'b1);
    alarm_link_in = 1'b1;
    @(negedge clk);
    cv(8'({host_link_oe_n, alarm_link_oe_n, host_link_out}), 8'h03);
    $display("t_reset done");
  endtask

  task automatic t_regs;
    host.wr(ADDR_SLEEP_HIGH, 8'hFF);
    host.wr(ADDR_PIN_MUX, 8'hFF);
    host.wr(ADDR_ENABLE_SECOND, 8'hFF);
    host.wr(ADDR_CONTROL_FLAGS, 8'hFD);
    cr(ADDR_ENABLE_SECOND, EN2_WRITABLE);
    cr(ADDR_CONTROL_FLAGS, CTL_WRITABLE);
    cr(ADDR_PIN_MUX, PMX_WRITABLE);
    cr(8'h0C, 8'h00);
    cb(host_regulator_enable, 1'b0);
    {host_link_in, led_enable_pin, horn_drive_pin} = 3'b111;
    @(negedge clk);
    cv(8'({alarm_link_oe_n, host_link_oe_n, alarm_link_out, led_block_enable,
           horn_block_enable}), 8'h0F);
    host.wr(ADDR_CONTROL_FLAGS, 8'h02);
    cr(ADDR_ENABLE_SECOND, 8'h40);
    cr(ADDR_CONTROL_FLAGS, 8'h00);
    cr(ADDR_SLEEP_HIGH, 8'h00);
    cr(ADDR_PIN_MUX, 8'h00);
    cb(host_regulator_enable, 1'b1);
    cv(8'({alarm_link_oe_n, host_link_oe_n, led_block_enable, horn_block_enable}),
       8'h08);
    host.wr(ADDR_ENABLE_SECOND, 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_sleep;
    host.wr(ADDR_SLEEP_LOW, 8'h03);
    host.wr(ADDR_ENABLE_SECOND, 8'h01);
    swait(0, 3 * TICK);
    cb(sleep_mode, 1'b0);
    cr(ADDR_ENABLE_SECOND, 8'h00);
    host.wr(ADDR_ENABLE_SECOND, 8'h01);
    host.wr(ADDR_ENABLE_SECOND, 8'h00);
    cb(sleep_mode, 1'b0);
    swait(2, 40);
    host.wr(ADDR_ENABLE_SECOND, 8'h01);
    host.wr(ADDR_SLEEP_LOW, 8'h08);
    swait(2, 3 * TICK);
    host.wr(ADDR_ENABLE_SECOND, 8'h01);
    swait(0, 8 * TICK);
    host.wr(ADDR_SLEEP_LOW, 8'h00);
    host.wr(ADDR_ENABLE_SECOND, 8'h01);
    swait(0, 40);
    cb(sleep_mode, 1'b1);
    host.wr(ADDR_SLEEP_LOW, 8'h02);
    swait(0, 2 * TICK);
    $display("t_sleep done");
  endtask

  task automatic t_boost;
    host.wr(ADDR_ENABLE_SECOND, 8'h40);
    cb(boost_run, 1'b1);
    boost_power_good = 1'b1;
    repeat (2) @(negedge clk);
    cb(boost_run, 1'b0);
    host.wr(ADDR_ENABLE_SECOND, 8'h00);
    host.wr(ADDR_CONTROL_FLAGS, 8'h01);
    supply_low_detect = 1'b1;
    repeat (2) @(negedge clk);
    cv(8'({supply_low_flag, boost_run}), 8'h03);
    host.wr(ADDR_CONTROL_FLAGS, 8'h11);
    @(negedge clk);
    cv(8'({supply_low_flag, boost_run}), 8'h00);
    {supply_low_detect, boost_power_good} = 2'b00;
    boost_enable_bit = 1'b1;
    @(negedge clk);
    cb(boost_run, 1'b1);
    boost_enable_bit = 1'b0;
    $display("t_boost done");
  endtask

  task automatic t_fault;
    regulator_error = 1'b1;
    repeat (2) @(negedge clk);
    cb(fault_mode, 1'b1);
    host.wr(ADDR_CONTROL_FLAGS, 8'h08);
    @(negedge clk);
    cb(fault_mode, 1'b0);
    {regulator_error, overtemp_event} = 2'b01;
    repeat (2) @(negedge clk);
    cv(8'({overtemp_flag, fault_mode}), 8'h00);
    host.wr(ADDR_CONTROL_FLAGS, 8'h04);
    @(negedge clk);
    cv(8'({overtemp_flag, fault_mode}), 8'h03);
    overtemp_event = 1'b0;
    $display("t_fault done");
  endtask

  task automatic t_pins;
    {gpio_in, status_error_any} = 2'b11;
    for (int s = 0; s < 8; s++) begin
      host.wr(ADDR_PIN_MUX, {s[2], 1'b0, s[1:0], 4'h0});
      cv(8'({analog_mux_select, amux_buffer_enable, amux_bypass_switch}),
         8'({s[1:0], !s[2] && s[1:0] != 2'h0, s[2] && s[1:0] != 2'h0}));
    end
    for (int i = 0; i < 5; i++) begin
      host.wr(ADDR_PIN_MUX, {5'h00, codes[i]});
      cv(8'({gpio_oe_n, led_a_enable, led_b_enable, battery_load_on}), 8'(pexp[i]));
      cb(gpio_out, codes[i] == PIN_ERROR);
    end
    $display("t_pins done");
  endtask

  task automatic final_report;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    {boost_enable_bit, boost_power_good, supply_low_detect, regulator_error, overtemp_event,
     alarm_link_in, host_link_in, led_enable_pin, horn_drive_pin, led_a_enable_input,
     led_b_enable_input, battery_load_enable, status_error_any, gpio_in} = '0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    t_reset;
    t_regs;
    t_sleep;
    t_boost;
    t_fault;
    t_pins;
    final_report;
  end
endmodule
